// ---- core/flash_margin_consts.svh ----
// Offsets, field positions, encodings and reset values of the margin command block
`ifndef FLASH_MARGIN_CONSTS_SVH
`define FLASH_MARGIN_CONSTS_SVH

// Register byte offsets
`define FMC_OFS_DIVIDER 8'h00
`define FMC_OFS_INDEX 8'h02
`define FMC_OFS_STATUS 8'h06
`define FMC_OFS_WORD_HI 8'h0a
`define FMC_OFS_WORD_LO 8'h0b
`define FMC_OFS_RSV_A 8'h0d
`define FMC_OFS_RSV_B 8'h0e
`define FMC_OFS_RSV_C 8'h0f
`define FMC_OFS_OPTION 8'h10
`define FMC_OFS_RSV_D 8'h11
`define FMC_OFS_RSV_E 8'h12
`define FMC_OFS_RSV_F 8'h13
`define FMC_OFS_INT_STAT 8'h14
`define FMC_OFS_INT_MASK 8'h15
`define FMC_OFS_MARGIN 8'h16
`define FMC_OFS_VER_HI 8'h18
`define FMC_OFS_VER_LO 8'h19

// Status register bits
`define FMC_ST_COMMAND_COMPLETE_FLAG 7
`define FMC_ST_ACCESS_ERROR_FLAG 5
`define FMC_ST_PROTECTION_VIOLATION_FLAG 4

// Divider register bits
`define FMC_DIV_LOADED 7
`define FMC_DIV_LOCK 6

// Interrupt status and mask bits
`define FMC_INT_DONE 0
`define FMC_INT_ERR 1

// Command encodings
`define FMC_CMD_MARGIN 8'h0d
`define FMC_IDX_LEVEL 3'h1
`define FMC_BLK_PFLASH 2'h0
`define FMC_BLK_EEPROM 2'h1
`define FMC_WORD_NORMAL 16'h0000
`define FMC_WORD_MARGIN1 16'h0001
`define FMC_WORD_MARGIN0 16'h0002
`define FMC_LVL_NORMAL 2'h0
`define FMC_LVL_ERASED 2'h1
`define FMC_LVL_PROGRAMMED 2'h2

// Information row layout
`define FMC_INFO_VERSION_ADDR 20'h040b6
`define FMC_INFO_ONCE_BYTES 64

// Reset values
`define FMC_DIVIDER_RST 8'h00
`define FMC_MASK_RST 8'h00

`endif

// ---- core/flash_margin_level_command.sv ----
// Margin level command sequencer with its register slave
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`include "flash_margin_consts.svh"
// What this block does
// - Level word 0x0000 means normal, 0x0001 erased-side margin, 0x0002 programmed-side margin.
// - Clearing the complete flag launches the command, which applies the level and sets the flag.
// - An EEPROM target changes only the EEPROM read level.
// - A program flash target changes both program flash and EEPROM read levels.
// - A launch with word index other than 1 raises the access error and does nothing else.
// - A launch when the command is not permitted raises the access error and does nothing else.
// - A launch with an invalid block code raises the access error.
// - A launch with an undefined level word raises the access error.
// - All divider bits read back, bit 7 ignores the written value and sets on any accepted write, bit 6 is write-once-high and locks.
// - In special mode the low seven divider bits take any number of writes, bit 7 never.
// - Each factory reserved register reads zero and ignores writes.
// - The information row holds a two-byte version identifier and a 64-byte once field.
module flash_margin_level_command
    import flash_margin_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    input wire logic I_SPECIAL_MODE,
    input wire logic I_MARGIN_CMD_PERMIT,
    input wire logic [7:0] I_NV_OPTION,
    input wire logic [15:0] I_VERSION_ID,
    output margin_level_t O_PFLASH_MARGIN,
    output margin_level_t O_EEPROM_MARGIN,
    output logic [5:0] O_TIMING_DIVIDER,
    output logic O_CMD_COMPLETE,
    output logic O_IRQ
);
    localparam int INFO_ONCE_BYTES = `FMC_INFO_ONCE_BYTES;
    localparam logic [19:0] INFO_VERSION_ADDR = `FMC_INFO_VERSION_ADDR;

    // The once field must be 64 bytes long and the version pair must start at an even address
    if (INFO_ONCE_BYTES != 64 || INFO_VERSION_ADDR[0] != 1'b0) begin : g_layout_check
        $error("information row layout constants are inconsistent");
    end

    cmd_state_t state_reg;
    cmd_state_t state_next;
    logic command_complete_flag_reg;
    logic [2:0] index_reg;
    logic [15:0] cmd_word_reg [0:1];
    logic [7:0] divider_reg;
    logic [7:0] option_reg;
    logic [7:0] mask_reg;
    logic [7:0] rdata_reg;
    logic irq_reg;
    margin_level_t pflash_margin_reg;
    margin_level_t eeprom_margin_reg;
    logic access_error_flag;
    logic protection_violation_flag;
    logic int_done;
    logic int_err;
    margin_level_t dec_level;
    logic dec_valid;

    // Address decode
    wire hit_div = (I_ADDR == `FMC_OFS_DIVIDER);
    wire hit_index = (I_ADDR == `FMC_OFS_INDEX);
    wire hit_stat = (I_ADDR == `FMC_OFS_STATUS);
    wire hit_hi = (I_ADDR == `FMC_OFS_WORD_HI);
    wire hit_lo = (I_ADDR == `FMC_OFS_WORD_LO);
    wire hit_opt = (I_ADDR == `FMC_OFS_OPTION);
    wire hit_istat = (I_ADDR == `FMC_OFS_INT_STAT);
    wire hit_mask = (I_ADDR == `FMC_OFS_INT_MASK);
    wire hit_margin = (I_ADDR == `FMC_OFS_MARGIN);
    wire hit_ver_hi = (I_ADDR == `FMC_OFS_VER_HI);
    wire hit_ver_lo = (I_ADDR == `FMC_OFS_VER_LO);
    wire hit_rsv = (I_ADDR == `FMC_OFS_RSV_A) || (I_ADDR == `FMC_OFS_RSV_B) ||
                   (I_ADDR == `FMC_OFS_RSV_C) || (I_ADDR == `FMC_OFS_RSV_D) ||
                   (I_ADDR == `FMC_OFS_RSV_E) || (I_ADDR == `FMC_OFS_RSV_F);

    wire wr_div = I_WR && hit_div;
    wire wr_stat = I_WR && hit_stat;
    wire wr_istat = I_WR && hit_istat;
    wire wr_mask = I_WR && hit_mask;
    // Command set-up registers freeze while a command runs
    wire wr_index = I_WR && hit_index && command_complete_flag_reg;
    wire word_sel_ok = (index_reg[2:1] == 2'b00);
    wire wr_hi = I_WR && hit_hi && command_complete_flag_reg && word_sel_ok;
    wire wr_lo = I_WR && hit_lo && command_complete_flag_reg && word_sel_ok;

    wire launch = wr_stat && I_WDATA[`FMC_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_reg && (state_reg == CMD_IDLE);
    wire in_exec = (state_reg == CMD_EXEC);

    // Checks made in the execute cycle on frozen parameters
    wire [15:0] word0 = cmd_word_reg[0];
    wire [15:0] word1 = cmd_word_reg[1];
    wire [1:0] blk_code = word0[1:0];
    wire err_index = (index_reg != `FMC_IDX_LEVEL);
    wire err_mode = !I_MARGIN_CMD_PERMIT;
    wire err_code = (word0[15:8] != `FMC_CMD_MARGIN);
    wire err_block = (blk_code != `FMC_BLK_PFLASH) && (blk_code != `FMC_BLK_EEPROM);
    wire err_level = !dec_valid;
    wire any_err = err_index | err_mode | err_code | err_block | err_level;
    wire exec_ok = in_exec && !any_err;
    wire exec_bad = in_exec && any_err;
    wire tgt_pflash = (blk_code == `FMC_BLK_PFLASH);

    margin_decoder u_decoder (
        .i_word(word1),
        .o_level(dec_level),
        .o_valid(dec_valid)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CMD_IDLE: begin
                if (launch) begin
                    state_next = CMD_EXEC;
                end
            end
            CMD_EXEC: begin
                state_next = CMD_IDLE;
            end
            default: begin
                state_next = CMD_IDLE;
            end
        endcase
    end

    // Program flash level also steers EEPROM reads; no flash-only setting exists
    wire margin_level_t pflash_next = (exec_ok && tgt_pflash) ? dec_level : pflash_margin_reg;
    wire margin_level_t eeprom_next = exec_ok ? dec_level : eeprom_margin_reg;

    // Divider: lock bit blocks writes in normal mode only
    wire div_open = I_SPECIAL_MODE || !divider_reg[`FMC_DIV_LOCK];
    wire [7:0] divider_next = (wr_div && div_open) ? {1'b1, I_WDATA[6:0]} : divider_reg;

    wire [7:0] stat_view = {command_complete_flag_reg, 1'b0, access_error_flag, protection_violation_flag, 4'h0};
    wire [7:0] int_view = {6'h00, int_err, int_done};
    wire [7:0] margin_view = {4'h0, eeprom_margin_reg, pflash_margin_reg};
    wire [7:0] word_hi_view = word_sel_ok ? cmd_word_reg[index_reg[0]][15:8] : 8'h00;
    wire [7:0] word_lo_view = word_sel_ok ? cmd_word_reg[index_reg[0]][7:0] : 8'h00;
    // Reserved and unmapped offsets fall through to zero
    wire [7:0] rd_mux = hit_div ? divider_reg :
                        hit_index ? {5'h00, index_reg} :
                        hit_stat ? stat_view :
                        hit_hi ? word_hi_view :
                        hit_lo ? word_lo_view :
                        hit_opt ? option_reg :
                        hit_istat ? int_view :
                        hit_mask ? mask_reg :
                        hit_margin ? margin_view :
                        hit_ver_hi ? I_VERSION_ID[15:8] :
                        hit_ver_lo ? I_VERSION_ID[7:0] :
                        8'h00;
    wire [7:0] rdata_next = I_RD ? rd_mux : 8'h00;
    wire irq_next = |(int_view & mask_reg);

    sticky_flag u_access_error_flag (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_set(exec_bad),
        .i_clr(wr_stat && I_WDATA[`FMC_ST_ACCESS_ERROR_FLAG]),
        .o_q(access_error_flag)
    );

    // Nothing in this command raises a protection violation
    sticky_flag u_protection_violation_flag (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_set(1'b0),
        .i_clr(wr_stat && I_WDATA[`FMC_ST_PROTECTION_VIOLATION_FLAG]),
        .o_q(protection_violation_flag)
    );

    sticky_flag u_int_done (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_set(in_exec),
        .i_clr(wr_istat && I_WDATA[`FMC_INT_DONE]),
        .o_q(int_done)
    );

    sticky_flag u_int_err (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_set(exec_bad),
        .i_clr(wr_istat && I_WDATA[`FMC_INT_ERR]),
        .o_q(int_err)
    );

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state_reg <= CMD_IDLE;
            command_complete_flag_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (launch) begin
                command_complete_flag_reg <= 1'b0;
            end else if (in_exec) begin
                command_complete_flag_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            index_reg <= 3'h0;
            cmd_word_reg[0] <= 16'h0000;
            cmd_word_reg[1] <= 16'h0000;
        end else begin
            if (wr_index) begin
                index_reg <= I_WDATA[2:0];
            end
            if (wr_hi) begin
                cmd_word_reg[index_reg[0]][15:8] <= I_WDATA;
            end
            if (wr_lo) begin
                cmd_word_reg[index_reg[0]][7:0] <= I_WDATA;
            end
        end
    end

    // Option byte follows the storage lines; software writes never reach it
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            option_reg <= 8'h00;
        end else begin
            option_reg <= I_NV_OPTION;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            divider_reg <= `FMC_DIVIDER_RST;
            mask_reg <= `FMC_MASK_RST;
            pflash_margin_reg <= `FMC_LVL_NORMAL;
            eeprom_margin_reg <= `FMC_LVL_NORMAL;
        end else begin
            divider_reg <= divider_next;
            pflash_margin_reg <= pflash_next;
            eeprom_margin_reg <= eeprom_next;
            if (wr_mask) begin
                mask_reg <= I_WDATA;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign O_RDATA = rdata_reg;
    assign O_IRQ = irq_reg;
    assign O_PFLASH_MARGIN = pflash_margin_reg;
    assign O_EEPROM_MARGIN = eeprom_margin_reg;
    assign O_TIMING_DIVIDER = divider_reg[5:0];
    assign O_CMD_COMPLETE = command_complete_flag_reg;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_ARST_N);

    sequence s_refused;
        access_error_flag && $stable(O_PFLASH_MARGIN) && $stable(O_EEPROM_MARGIN);
    endsequence

    sequence s_done_cycle;
        !O_CMD_COMPLETE ##1 O_CMD_COMPLETE;
    endsequence

    property p_launch_completes;
        launch |=> s_done_cycle;
    endproperty
    a_launch_completes: assert property (p_launch_completes)
        else $error("complete flag did not drop and return after launch");

    property p_level_decode;
        dec_valid |-> (word1 == `FMC_WORD_NORMAL && dec_level == `FMC_LVL_NORMAL) ||
                      (word1 == `FMC_WORD_MARGIN1 && dec_level == `FMC_LVL_ERASED) ||
                      (word1 == `FMC_WORD_MARGIN0 && dec_level == `FMC_LVL_PROGRAMMED);
    endproperty
    a_level_decode: assert property (p_level_decode)
        else $error("margin level word decoded wrongly");

    property p_eeprom_only;
        exec_ok && blk_code == `FMC_BLK_EEPROM |=>
            O_EEPROM_MARGIN == $past(dec_level) && $stable(O_PFLASH_MARGIN);
    endproperty
    a_eeprom_only: assert property (p_eeprom_only)
        else $error("EEPROM target disturbed program flash level");

    property p_pflash_both;
        exec_ok && tgt_pflash |=>
            O_PFLASH_MARGIN == $past(dec_level) && O_EEPROM_MARGIN == $past(dec_level);
    endproperty
    a_pflash_both: assert property (p_pflash_both)
        else $error("program flash target did not set both levels");

    property p_bad_index;
        in_exec && index_reg != `FMC_IDX_LEVEL |=> s_refused;
    endproperty
    a_bad_index: assert property (p_bad_index)
        else $error("wrong word index not refused");

    property p_not_permitted;
        in_exec && !I_MARGIN_CMD_PERMIT |=> s_refused;
    endproperty
    a_not_permitted: assert property (p_not_permitted)
        else $error("unpermitted command not refused");

    property p_bad_block;
        in_exec && blk_code != `FMC_BLK_PFLASH && blk_code != `FMC_BLK_EEPROM |=> s_refused;
    endproperty
    a_bad_block: assert property (p_bad_block)
        else $error("invalid block code not refused");

    property p_bad_level;
        in_exec && !dec_valid |=> s_refused;
    endproperty
    a_bad_level: assert property (p_bad_level)
        else $error("undefined level word not refused");

    property p_protection_violation_flag_held;
        in_exec |=> protection_violation_flag == $past(protection_violation_flag) || $past(wr_stat);
    endproperty
    a_protection_violation_flag_held: assert property (p_protection_violation_flag_held)
        else $error("command changed protection violation flag");

    property p_div_locked;
        wr_div && !I_SPECIAL_MODE && divider_reg[`FMC_DIV_LOCK] |=> $stable(divider_reg);
    endproperty
    a_div_locked: assert property (p_div_locked)
        else $error("locked divider accepted a write");

    property p_div_special;
        wr_div && I_SPECIAL_MODE |=>
            divider_reg[6:0] == $past(I_WDATA[6:0]) && divider_reg[`FMC_DIV_LOADED];
    endproperty
    a_div_special: assert property (p_div_special)
        else $error("special mode divider write not taken");

    property p_rsv_zero;
        I_RD && hit_rsv |=> O_RDATA == 8'h00;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved register read non-zero");

    property p_version_read;
        I_RD && hit_ver_hi |=> O_RDATA == $past(I_VERSION_ID[15:8]);
    endproperty
    a_version_read: assert property (p_version_read)
        else $error("version identifier read wrong");

    property p_option_ro;
        I_WR && hit_opt ##1 I_RD && hit_opt |=> O_RDATA == $past(option_reg);
    endproperty
    a_option_ro: assert property (p_option_ro)
        else $error("option byte affected by write");
endmodule // flash_margin_level_command

// ---- core/flash_margin_pkg.sv ----
// Types shared by the margin command block
package flash_margin_pkg;
    typedef enum logic {CMD_IDLE, CMD_EXEC} cmd_state_t;
    typedef logic [1:0] margin_level_t;
endpackage

// ---- core/margin_decoder.sv ----
// Decoder of the margin level parameter word
`timescale 1ns/10ps
`include "flash_margin_consts.svh"
module margin_decoder
    import flash_margin_pkg::*;
(
    input wire logic [15:0] i_word,
    output margin_level_t o_level,
    output logic o_valid
);
    wire is_normal = (i_word == `FMC_WORD_NORMAL);
    wire is_erased = (i_word == `FMC_WORD_MARGIN1);
    wire is_programmed = (i_word == `FMC_WORD_MARGIN0);
    assign o_valid = is_normal | is_erased | is_programmed;
    assign o_level = is_erased ? `FMC_LVL_ERASED :
                     is_programmed ? `FMC_LVL_PROGRAMMED : `FMC_LVL_NORMAL;
endmodule // margin_decoder

// ---- core/sticky_flag.sv ----
// Sticky flag, hardware set wins over software clear
`timescale 1ns/10ps
module sticky_flag (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_set,
    input wire logic i_clr,
    output logic o_q
);
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_q <= 1'b0;
        end else if (i_set) begin
            o_q <= 1'b1;
        end else if (i_clr) begin
            o_q <= 1'b0;
        end
    end
endmodule // sticky_flag

// ---- dv/flash_margin_level_command_tb.sv ----
// Self-checking bench of the margin level command block
`timescale 1ns/10ps
`include "flash_margin_consts.svh"
module flash_margin_level_command_tb
    import flash_margin_pkg::*;
;
    logic I_CLK = 1'b0;
    logic I_ARST_N;
    logic [7:0] I_ADDR;
    logic [7:0] I_WDATA;
    logic I_WR;
    logic I_RD;
    logic [7:0] O_RDATA;
    logic I_SPECIAL_MODE;
    logic I_MARGIN_CMD_PERMIT;
    logic [7:0] I_NV_OPTION;
    logic [15:0] I_VERSION_ID;
    margin_level_t O_PFLASH_MARGIN;
    margin_level_t O_EEPROM_MARGIN;
    logic [5:0] O_TIMING_DIVIDER;
    logic O_CMD_COMPLETE;
    logic O_IRQ;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    logic rd_q = 1'b0;
    logic chk_busy = 1'b0;
    logic [7:0] exp_q[$];
    margin_level_t pf_m;
    margin_level_t ee_m;
    logic [7:0] rsv[6] = '{`FMC_OFS_RSV_A, `FMC_OFS_RSV_B, `FMC_OFS_RSV_C,
                           `FMC_OFS_RSV_D, `FMC_OFS_RSV_E, `FMC_OFS_RSV_F};

    always #2.5 I_CLK = ~I_CLK;

    flash_margin_level_command DUT (
        .I_CLK(I_CLK),
        .I_ARST_N(I_ARST_N),
        .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA),
        .I_WR(I_WR),
        .I_RD(I_RD),
        .O_RDATA(O_RDATA),
        .I_SPECIAL_MODE(I_SPECIAL_MODE),
        .I_MARGIN_CMD_PERMIT(I_MARGIN_CMD_PERMIT),
        .I_NV_OPTION(I_NV_OPTION),
        .I_VERSION_ID(I_VERSION_ID),
        .O_PFLASH_MARGIN(O_PFLASH_MARGIN),
        .O_EEPROM_MARGIN(O_EEPROM_MARGIN),
        .O_TIMING_DIVIDER(O_TIMING_DIVIDER),
        .O_CMD_COMPLETE(O_CMD_COMPLETE),
        .O_IRQ(O_IRQ)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Strobes stay up until the next call, so no signal is assigned twice in one step
    task automatic bus(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
        I_WR <= wr;
        I_RD <= rd;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    // Read data only stand in the cycle after the strobe, so look mid-cycle
    always @(posedge I_CLK) rd_q <= I_RD;
    always @(negedge I_CLK) begin
        if (rd_q && exp_q.size() > 0) begin
            check(O_RDATA, exp_q.pop_front(), "read data");
        end
        if (chk_busy) begin
            check({7'h00, O_CMD_COMPLETE}, 8'h00, "complete low after launch");
            chk_busy = 1'b0;
        end
    end

    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic run_cmd(input logic [2:0] idx, input logic [7:0] code, input logic [1:0] blk,
            input logic [15:0] word, input logic permit, input logic [7:0] mask);
        logic err;
        logic irq;
        int n;
        err = (idx != `FMC_IDX_LEVEL) || !permit || (code != `FMC_CMD_MARGIN)
            || (blk > `FMC_BLK_EEPROM) || (word > `FMC_WORD_MARGIN0);
        irq = (err && mask[`FMC_INT_ERR]) || mask[`FMC_INT_DONE];
        I_MARGIN_CMD_PERMIT <= permit;
        wr(`FMC_OFS_INT_MASK, mask);
        wr(`FMC_OFS_INDEX, 8'h00);
        wr(`FMC_OFS_WORD_HI, code);
        wr(`FMC_OFS_WORD_LO, {6'h00, blk});
        wr(`FMC_OFS_INDEX, 8'h01);
        wr(`FMC_OFS_WORD_LO, word[7:0]);
        wr(`FMC_OFS_WORD_HI, word[15:8]);
        wr(`FMC_OFS_INDEX, {5'h00, idx});
        wr(`FMC_OFS_STATUS, 8'h80);
        chk_busy = 1'b1;
        idle(1);
        // Look mid-cycle so the flag is settled, then rejoin the rising edge
        @(negedge I_CLK);
        n = 0;
        while (O_CMD_COMPLETE !== 1'b1 && n < 8) begin
            @(negedge I_CLK);
            n++;
        end
        @(posedge I_CLK);
        check(8'(n), 8'h00, "completion delay");
        if (!err && blk == `FMC_BLK_PFLASH) begin
            pf_m = word[1:0];
            ee_m = word[1:0];
        end else if (!err) begin
            ee_m = word[1:0];
        end
        rd(`FMC_OFS_STATUS, err ? 8'ha0 : 8'h80);
        rd(`FMC_OFS_MARGIN, {4'h0, ee_m, pf_m});
        check({6'h00, O_PFLASH_MARGIN}, {6'h00, pf_m}, "program flash level");
        check({6'h00, O_EEPROM_MARGIN}, {6'h00, ee_m}, "eeprom level");
        check({7'h00, O_IRQ}, {7'h00, irq}, "interrupt raised");
        wr(`FMC_OFS_STATUS, 8'h20);
        wr(`FMC_OFS_INT_STAT, 8'h03);
        idle(3);
        check({7'h00, O_IRQ}, 8'h00, "interrupt cleared");
    endtask

    initial begin
        I_ARST_N = 1'b0;
        I_ADDR = 8'h00;
        I_WDATA = 8'h00;
        I_WR = 1'b0;
        I_RD = 1'b0;
        I_SPECIAL_MODE = 1'b0;
        I_MARGIN_CMD_PERMIT = 1'b1;
        pf_m = `FMC_LVL_NORMAL;
        ee_m = `FMC_LVL_NORMAL;
        void'($urandom(42));
        I_NV_OPTION = 8'($urandom());
        I_VERSION_ID = 16'($urandom());
        repeat (5) @(posedge I_CLK);
        I_ARST_N <= 1'b1;
        @(posedge I_CLK);
        rd(`FMC_OFS_DIVIDER, `FMC_DIVIDER_RST);
        rd(`FMC_OFS_STATUS, 8'h80);
        rd(`FMC_OFS_MARGIN, 8'h00);
        rd(`FMC_OFS_INT_MASK, `FMC_MASK_RST);
        idle(2);
        check({7'h00, O_CMD_COMPLETE}, 8'h01, "complete after reset");
        $display("Test reset_values done");

        foreach (rsv[i]) begin
            wr(rsv[i], 8'($urandom()) | 8'h01);
            rd(rsv[i], 8'h00);
        end
        wr(`FMC_OFS_OPTION, ~I_NV_OPTION);
        rd(`FMC_OFS_OPTION, I_NV_OPTION);
        rd(`FMC_OFS_VER_HI, I_VERSION_ID[15:8]);
        rd(`FMC_OFS_VER_LO, I_VERSION_ID[7:0]);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        $display("Test read_only_places done");

        wr(`FMC_OFS_DIVIDER, 8'h25);
        rd(`FMC_OFS_DIVIDER, 8'ha5);
        wr(`FMC_OFS_DIVIDER, 8'hc3);
        rd(`FMC_OFS_DIVIDER, 8'hc3);
        wr(`FMC_OFS_DIVIDER, 8'h11);
        rd(`FMC_OFS_DIVIDER, 8'hc3);
        check({2'h0, O_TIMING_DIVIDER}, 8'h03, "divider locked");
        I_SPECIAL_MODE <= 1'b1;
        wr(`FMC_OFS_DIVIDER, 8'h0a);
        rd(`FMC_OFS_DIVIDER, 8'h8a);
        wr(`FMC_OFS_DIVIDER, 8'h7f);
        rd(`FMC_OFS_DIVIDER, 8'hff);
        wr(`FMC_OFS_DIVIDER, 8'h05);
        rd(`FMC_OFS_DIVIDER, 8'h85);
        check({2'h0, O_TIMING_DIVIDER}, 8'h05, "divider special");
        I_SPECIAL_MODE <= 1'b0;
        $display("Test divider_lock done");

        run_cmd(3'h1, `FMC_CMD_MARGIN, `FMC_BLK_PFLASH, `FMC_WORD_MARGIN1, 1'b1, 8'h02);
        run_cmd(3'h1, `FMC_CMD_MARGIN, `FMC_BLK_EEPROM, `FMC_WORD_MARGIN0, 1'b1, 8'h02);
        run_cmd(3'h1, `FMC_CMD_MARGIN, `FMC_BLK_EEPROM, `FMC_WORD_NORMAL, 1'b1, 8'h02);
        run_cmd(3'h1, `FMC_CMD_MARGIN, `FMC_BLK_PFLASH, `FMC_WORD_MARGIN0, 1'b1, 8'h02);
        run_cmd(3'h0, `FMC_CMD_MARGIN, `FMC_BLK_PFLASH, `FMC_WORD_NORMAL, 1'b1, 8'h02);
        run_cmd(3'h2, `FMC_CMD_MARGIN, `FMC_BLK_EEPROM, `FMC_WORD_NORMAL, 1'b1, 8'h02);
        run_cmd(3'h1, `FMC_CMD_MARGIN, `FMC_BLK_PFLASH, `FMC_WORD_NORMAL, 1'b0, 8'h02);
        run_cmd(3'h1, `FMC_CMD_MARGIN, 2'h2, `FMC_WORD_NORMAL, 1'b1, 8'h02);
        run_cmd(3'h1, `FMC_CMD_MARGIN, 2'h3, `FMC_WORD_MARGIN1, 1'b1, 8'h02);
        run_cmd(3'h1, `FMC_CMD_MARGIN, `FMC_BLK_EEPROM, 16'h0003, 1'b1, 8'h02);
        run_cmd(3'h1, `FMC_CMD_MARGIN, `FMC_BLK_PFLASH, 16'h0100, 1'b1, 8'h02);
        run_cmd(3'h1, 8'h0c, `FMC_BLK_PFLASH, `FMC_WORD_NORMAL, 1'b1, 8'h02);
        run_cmd(3'h1, `FMC_CMD_MARGIN, `FMC_BLK_PFLASH, `FMC_WORD_NORMAL, 1'b1, 8'h01);
        $display("Test command_table done");

        repeat (8) begin
            run_cmd(3'h1, `FMC_CMD_MARGIN, 2'($urandom()), 16'($urandom() % 4), 1'b1,
                8'($urandom() % 4));
        end
        $display("Test command_random done");

        idle(3);
        check(8'(exp_q.size()), 8'h00, "reads left unanswered");
        end_of_test();
    end
endmodule // flash_margin_level_command_tb
